// [shared/keypad_pkg.sv]
package keypad_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [31:0] STATUS_CONTROL_ADDR = 32'h0000_0000;
    localparam logic [31:0] PIN_ENABLE_ADDR = 32'h0000_0004;

    // ==========================================================
    // Status and control field positions
    // ==========================================================
    localparam int SENSE_POS = 0;
    localparam int MASK_POS = 1;
    localparam int ACK_POS = 2;
    localparam int PENDING_POS = 3;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic RESET_SENSE = 1'b0;
    localparam logic RESET_MASK = 1'b0;
    localparam logic RESET_PENDING = 1'b0;
    localparam logic [7:0] RESET_PIN_ENABLE = 8'h00;

    // ==========================================================
    // AHB-Lite encodings
    // ==========================================================
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    typedef struct packed {
        logic sel;
        logic write;
        logic [31:0] addr;
    } bus_req_s;

    typedef struct packed {
        logic wait_mode;
        logic stop_mode;
        logic break_state;
        logic break_clear_enable;
        logic vector_fetch;
    } cpu_status_s;

endpackage : keypad_pkg

// [core/keypad_pin_interrupt.sv]
`timescale 1ns/1ns
// How it works
// - Five enableable key inputs shared with port pins feed one maskable request.
// - Each pin-enable bit selects whether its pin is a key input.
// - An enabled key pin also has its pull-up switched on.
// - Latch a request when an enabled pin falls while all were high.
// - Edge-only mode ignores a fall while another enabled pin is low.
// - Edge-and-level mode keeps the request while any enabled pin is low.
// - Edge-and-level mode clears only after acknowledge and all pins high.
// - A vector fetch acknowledges the request like the software acknowledge.
// - Writing one to the acknowledge bit clears the request; it reads zero.
// - A fall after the acknowledge write latches a fresh request.
// - Unmasked requests make the CPU fetch the vector at FFD2 and FFD3.
// - Edge-only mode clears the request at once on acknowledge.
// - Reset clears the request and the sensitivity select, even with pins low.
// - The pending flag shows the latched request, unaffected by the mask.
// - Mask bit one keeps the request from the CPU; reset clears it.
// - Sensitivity select one means edges plus levels, zero edges only.
// - Upper 28 bits of status and control read as zero.
// - An enabled key pin is forced to input, overriding its direction.
// - Port data shows the pin level only when its direction bit is zero.
// - Reset clears all pin-enable bits.
// - The block runs in wait and stop; an unmasked request wakes the CPU.
// - In break with clear-enable zero, acknowledge writes are ignored.
// - With clear-enable one, a clear made in break stays cleared.
module keypad_pin_interrupt #(
    parameter int NUM_KEYS = 5
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // CPU status from the system integration unit
    input wire keypad_pkg::cpu_status_s cpu_status_i,
    // Key pins and port interaction
    input wire logic [NUM_KEYS-1:0] keypad_input_pin_i,
    input wire logic [NUM_KEYS-1:0] port_dir_i,
    output logic [NUM_KEYS-1:0] pull_up_en_o,
    output logic [NUM_KEYS-1:0] port_dir_o,
    output logic [NUM_KEYS-1:0] port_readable_o,
    // Requests toward the CPU
    output logic cpu_irq_o,
    output logic wake_o,
    output logic request_pending_flag_o
);
    import keypad_pkg::*;

    // ==========================================================
    // Bus slave
    // ==========================================================
    // Writes land in the data phase, so the address phase is kept.
    bus_req_s dphase_q;
    bus_req_s dphase_d;
    logic sense_q;
    logic mask_q;
    logic pending_q;
    logic pending_d;
    logic [NUM_KEYS-1:0] enable_q;
    wire logic trans_valid;
    wire logic hit_ctrl;
    wire logic hit_en;
    wire logic wr_ctrl;
    wire logic wr_en;
    wire logic [31:0] rd_ctrl;
    wire logic [31:0] rd_en;

    assign trans_valid = hsel_i && hready_i &&
        (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
    assign dphase_d = '{sel: trans_valid, write: hwrite_i, addr: haddr_i};
    assign hit_ctrl = dphase_q.addr == STATUS_CONTROL_ADDR;
    assign hit_en = dphase_q.addr == PIN_ENABLE_ADDR;
    assign wr_ctrl = dphase_q.sel && dphase_q.write && hit_ctrl;
    assign wr_en = dphase_q.sel && dphase_q.write && hit_en;
    // Acknowledge reads as zero; upper bits read as zero.
    assign rd_ctrl = {28'h000_0000, pending_q, 1'b0, mask_q, sense_q};
    assign rd_en = {{(32-NUM_KEYS){1'b0}}, enable_q};
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dphase_q <= '0;
        end else begin
            dphase_q <= dphase_d;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (trans_valid && !hwrite_i) begin
            hrdata_o <= (haddr_i == STATUS_CONTROL_ADDR) ? rd_ctrl :
                        (haddr_i == PIN_ENABLE_ADDR) ? rd_en : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Control registers
    // ==========================================================
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sense_q <= RESET_SENSE;
            mask_q <= RESET_MASK;
            enable_q <= RESET_PIN_ENABLE[NUM_KEYS-1:0];
        end else begin
            if (wr_ctrl) begin
                sense_q <= hwdata_i[SENSE_POS];
                mask_q <= hwdata_i[MASK_POS];
            end
            if (wr_en) begin
                enable_q <= hwdata_i[NUM_KEYS-1:0];
            end
        end
    end

    // ==========================================================
    // Pin synchroniser and port control
    // ==========================================================
    logic [NUM_KEYS-1:0] pin_meta_q;
    logic [NUM_KEYS-1:0] pin_sync_q;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta_q <= '1;
            pin_sync_q <= '1;
        end else begin
            pin_meta_q <= keypad_input_pin_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    assign pull_up_en_o = enable_q;
    assign port_dir_o = port_dir_i & ~enable_q;
    assign port_readable_o = ~port_dir_i;

    // ==========================================================
    // Request latch
    // ==========================================================
    // An enabled pin reads low when its synchronised level is low.
    logic any_low_q;
    wire logic any_low;
    wire logic fall;
    wire logic ack_write;
    wire logic ack;
    logic ack_seen_q;
    wire logic ack_seen;

    assign any_low = |(enable_q & ~pin_sync_q);
    assign fall = any_low && !any_low_q;
    // With break clear-enable low, acknowledge writes during break do nothing.
    assign ack_write = wr_ctrl && hwdata_i[ACK_POS] &&
        (!cpu_status_i.break_state || cpu_status_i.break_clear_enable);
    assign ack = ack_write || cpu_status_i.vector_fetch;
    assign ack_seen = ack_seen_q || ack;

    // New edges win over an acknowledge in the same cycle.
    always_comb begin
        pending_d = pending_q;
        if (fall) begin
            pending_d = 1'b1;
        end else if (!sense_q && ack) begin
            pending_d = 1'b0;
        end else if (sense_q && ack_seen && !any_low) begin
            pending_d = 1'b0;
        end else if (sense_q && any_low) begin
            pending_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            any_low_q <= 1'b0;
            pending_q <= RESET_PENDING;
            ack_seen_q <= 1'b0;
        end else begin
            any_low_q <= any_low;
            pending_q <= pending_d;
            ack_seen_q <= pending_d && ack_seen && !fall;
        end
    end

    // ==========================================================
    // Outputs to the CPU
    // ==========================================================
    // The vector at FFD2/FFD3 is fetched by the CPU on this request.
    assign cpu_irq_o = pending_q && !mask_q;
    // No clock gating here, so the latch keeps working in wait and stop.
    assign wake_o = cpu_irq_o && (cpu_status_i.wait_mode || cpu_status_i.stop_mode);
    assign request_pending_flag_o = pending_q;

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_all_high;
        !any_low;
    endsequence

    sequence s_fall;
        any_low && !any_low_q;
    endsequence

    a_fall_latches: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_fall |=> pending_q)
        else $error("Falling edge did not latch request.");

    a_edge_ack_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!sense_q && ack && !fall) |=> !pending_q)
        else $error("Edge mode acknowledge did not clear.");

    a_level_holds: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (sense_q && any_low) |=> pending_q)
        else $error("Level mode request dropped while pin low.");

    a_no_fall_blocked: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!sense_q && !pending_q && any_low_q && !ack) |=> !pending_q)
        else $error("Request latched while a pin was already low.");

    a_mask_gates: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        cpu_irq_o == (pending_q && !mask_q))
        else $error("CPU request not gated by mask.");

    a_break_protect: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_ctrl && cpu_status_i.break_state && !cpu_status_i.break_clear_enable
         && !cpu_status_i.vector_fetch && !sense_q && pending_q) |=> pending_q)
        else $error("Acknowledge in break altered the latch.");

    a_ack_reads_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        rd_ctrl[31:4] == 28'h000_0000 && !rd_ctrl[ACK_POS])
        else $error("Acknowledge or unused bits read nonzero.");

    a_level_release: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (sense_q && ack && !any_low && !fall) ##1 s_all_high |-> !pending_q)
        else $error("Level mode request not released.");

    a_pullup_follows: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_en |=> pull_up_en_o == $past(hwdata_i[NUM_KEYS-1:0]))
        else $error("Pull-up does not follow enable write.");

    // ==========================================================
    // Outputs and port control checks
    // ==========================================================
    a_irq_needs_pending: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        cpu_irq_o |-> request_pending_flag_o)
        else $error("CPU request without a pending flag.");

    a_flag_is_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        request_pending_flag_o == pending_q)
        else $error("Pending flag differs from the latch.");

    a_wake_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (cpu_irq_o && cpu_status_i.wait_mode) |-> wake_o)
        else $error("Request did not wake from wait.");

    a_wake_stop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (cpu_irq_o && cpu_status_i.stop_mode) |-> wake_o)
        else $error("Request did not wake from stop.");

    a_wake_needs_mode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wake_o |-> (cpu_status_i.wait_mode || cpu_status_i.stop_mode))
        else $error("Wake raised outside a low-power mode.");

    a_no_wake_masked: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        mask_q |-> !wake_o)
        else $error("Masked request woke the CPU.");

    a_pullup_enable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        pull_up_en_o == enable_q)
        else $error("Pull-up differs from pin enable.");

    a_dir_override: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (port_dir_o & enable_q) == '0)
        else $error("Enabled key pin left as output.");

    a_readable_dir: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        port_readable_o == ~port_dir_i)
        else $error("Pin readability does not follow direction.");

    a_disabled_pins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (enable_q == '0) |-> !any_low)
        else $error("Disabled pins seen as key inputs.");

    a_sync_two_stage: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        pin_sync_q == $past(pin_meta_q))
        else $error("Synchroniser second stage skipped.");

    // ==========================================================
    // Request latch checks
    // ==========================================================
    a_vector_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!sense_q && cpu_status_i.vector_fetch && !fall) |=> !pending_q)
        else $error("Vector fetch did not clear the request.");

    a_ack_write_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!sense_q && ack_write && !fall) |=> !pending_q)
        else $error("Acknowledge write did not clear the request.");

    a_fresh_after_ack: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (ack && fall) |=> pending_q)
        else $error("Fall with acknowledge was lost.");

    a_level_no_early: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (sense_q && pending_q && any_low) |=> pending_q)
        else $error("Level request cleared while a pin was low.");

    a_level_ack_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (sense_q && pending_q && !ack_seen && !fall) |=> pending_q)
        else $error("Level request cleared without acknowledge.");

    a_ack_seen_pending: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ack_seen_q |-> pending_q)
        else $error("Stored acknowledge without a request.");

    a_edge_no_level: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!sense_q && !pending_q && !fall) |=> !pending_q)
        else $error("Edge mode latched on a level.");

    a_clear_persists: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!pending_q && !fall && !(sense_q && any_low)) |=> !pending_q)
        else $error("Cleared latch came back without a cause.");

    a_no_ack_in_break: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (cpu_status_i.break_state && !cpu_status_i.break_clear_enable) |-> !ack_write)
        else $error("Acknowledge write acted during protected break.");

    a_break_clear_ok: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_ctrl && hwdata_i[ACK_POS] && cpu_status_i.break_clear_enable) |-> ack_write)
        else $error("Acknowledge write refused with clear-enable set.");

    a_mask_keeps_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_ctrl && !hwdata_i[ACK_POS] && !cpu_status_i.vector_fetch && !fall && !sense_q)
        |=> pending_q == $past(pending_q))
        else $error("Mask write changed the pending flag.");

    // ==========================================================
    // Register checks
    // ==========================================================
    a_sense_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_ctrl |=> sense_q == $past(hwdata_i[SENSE_POS]))
        else $error("Sensitivity select not written.");

    a_mask_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_ctrl |=> mask_q == $past(hwdata_i[MASK_POS]))
        else $error("Mask bit not written.");

    a_enable_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_en |=> enable_q == $past(hwdata_i[NUM_KEYS-1:0]))
        else $error("Pin enable not written.");

    a_enable_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !wr_en |=> $stable(enable_q))
        else $error("Pin enable changed without a write.");

    a_sense_reads: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        rd_ctrl[SENSE_POS] == sense_q)
        else $error("Sensitivity select reads wrong.");

    a_ready_always: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        hreadyout_o && !hresp_o)
        else $error("Bus slave stalled or answered with error.");

    a_read_ctrl: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (trans_valid && !hwrite_i && haddr_i == STATUS_CONTROL_ADDR)
        |=> hrdata_o == $past(rd_ctrl))
        else $error("Status read returned wrong data.");

    a_read_enable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (trans_valid && !hwrite_i && haddr_i == PIN_ENABLE_ADDR)
        |=> hrdata_o == $past(rd_en))
        else $error("Pin enable read returned wrong data.");

    a_unmapped_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (trans_valid && !hwrite_i && haddr_i != STATUS_CONTROL_ADDR
         && haddr_i != PIN_ENABLE_ADDR) |=> hrdata_o == 32'h0000_0000)
        else $error("Unmapped read returned nonzero data.");

    a_hold_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !(trans_valid && !hwrite_i) |=> $stable(hrdata_o))
        else $error("Read data changed without a read.");

endmodule : keypad_pin_interrupt

// [testbench/key_model.sv]
`timescale 1ns/1ns
// ==========================================================
// Key switches on the five port pins
// ==========================================================
module key_model (
    // Clock
    input wire logic sys_clk_i,
    // Pin control from the block and key presses from the bench
    input wire logic [4:0] pull_up_en_i,
    input wire logic [4:0] press_i,
    // Pin levels
    output logic [4:0] pin_o
);
    logic [4:0] float_q = 5'h00;

    // A pin with neither key nor pull-up floats, so it changes every cycle.
    always @(posedge sys_clk_i) begin
        float_q <= ~float_q;
    end

    assign pin_o = ~press_i & (pull_up_en_i | float_q);
endmodule : key_model

// [testbench/keypad_pin_interrupt_tb_top.sv]
`timescale 1ns/1ns
module keypad_pin_interrupt_tb_top;
    import keypad_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [1:0] htrans = 2'h0;
    logic hrdy, hresp, irq, wake, pend;
    cpu_status_s cpu = '0;
    logic [4:0] press = 5'h00;
    logic [4:0] dir = 5'h1F;
    logic [4:0] pin, pu, dir_o, rdbl;
    int n_fail = 0;
    int n_tests = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    keypad_pin_interrupt DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
        .hresp_o(hresp), .cpu_status_i(cpu), .keypad_input_pin_i(pin), .port_dir_i(dir),
        .pull_up_en_o(pu), .port_dir_o(dir_o), .port_readable_o(rdbl), .cpu_irq_o(irq),
        .wake_o(wake), .request_pending_flag_o(pend));
    key_model keys (.sys_clk_i(sys_clk_i), .pull_up_en_i(pu), .press_i(press), .pin_o(pin));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wait_rdy;
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk_i);
            if (hrdy === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            end_of_test();
        end
    endtask : wait_rdy

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge sys_clk_i);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rd

    // Lets the synchroniser and the request latch settle before sampling.
    task automatic settle;
        repeat (3) @(posedge sys_clk_i);
        #1;
    endtask : settle

    task automatic key(input logic [4:0] p);
        @(posedge sys_clk_i);
        press <= p;
        repeat (3) @(posedge sys_clk_i);
        settle();
    endtask : key

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic s_edge;
        rd("status", STATUS_CONTROL_ADDR, 32'h0);
        rd("enable", PIN_ENABLE_ADDR, 32'h0);
        rd("unmapped", 32'h8, 32'h0);
        chk("hresp", 32'h0, hresp);
        wr(PIN_ENABLE_ADDR, 32'h1F);
        rd("enable", PIN_ENABLE_ADDR, 32'h1F);
        chk("pullup", 32'h1F, pu);
        chk("dir", 32'h0, dir_o);
        chk("readable", 32'h0, rdbl);
        key(5'h01);
        chk("pending", 32'h1, pend);
        chk("irq", 32'h1, irq);
        rd("status", STATUS_CONTROL_ADDR, 32'h8);
        wr(STATUS_CONTROL_ADDR, 32'h4);
        settle();
        chk("pending", 32'h0, pend);
        rd("status", STATUS_CONTROL_ADDR, 32'h0);
        key(5'h03);
        chk("pending", 32'h0, pend);
        key(5'h00);
        key(5'h04);
        chk("pending", 32'h1, pend);
        wr(STATUS_CONTROL_ADDR, 32'h2);
        rd("status", STATUS_CONTROL_ADDR, 32'hA);
        chk("irq", 32'h0, irq);
        @(posedge sys_clk_i);
        cpu.wait_mode <= 1'b1;
        wr(STATUS_CONTROL_ADDR, 32'h0);
        settle();
        chk("wake", 32'h1, wake);
        @(posedge sys_clk_i);
        cpu.wait_mode <= 1'b0;
        cpu.stop_mode <= 1'b1;
        #1;
        chk("wake", 32'h1, wake);
        @(posedge sys_clk_i);
        cpu <= '0;
        @(posedge sys_clk_i);
        chk("wake", 32'h0, wake);
        cpu.vector_fetch <= 1'b1;
        @(posedge sys_clk_i);
        cpu.vector_fetch <= 1'b0;
        settle();
        chk("pending", 32'h0, pend);
        key(5'h00);
    endtask : s_edge

    task automatic s_level;
        wr(STATUS_CONTROL_ADDR, 32'h1);
        key(5'h02);
        wr(STATUS_CONTROL_ADDR, 32'h5);
        settle();
        chk("pending", 32'h1, pend);
        key(5'h00);
        chk("pending", 32'h0, pend);
        key(5'h10);
        key(5'h00);
        chk("pending", 32'h1, pend);
        wr(STATUS_CONTROL_ADDR, 32'h5);
        settle();
        chk("pending", 32'h0, pend);
    endtask : s_level

    task automatic s_break;
        wr(STATUS_CONTROL_ADDR, 32'h0);
        key(5'h08);
        @(posedge sys_clk_i);
        cpu.break_state <= 1'b1;
        wr(STATUS_CONTROL_ADDR, 32'h4);
        settle();
        chk("pending", 32'h1, pend);
        @(posedge sys_clk_i);
        cpu.break_clear_enable <= 1'b1;
        wr(STATUS_CONTROL_ADDR, 32'h4);
        @(posedge sys_clk_i);
        cpu <= '0;
        settle();
        chk("pending", 32'h0, pend);
        key(5'h00);
    endtask : s_break

    task automatic s_reset;
        wr(STATUS_CONTROL_ADDR, 32'h1);
        key(5'h01);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        settle();
        chk("pending", 32'h0, pend);
        rd("status", STATUS_CONTROL_ADDR, 32'h0);
        rd("enable", PIN_ENABLE_ADDR, 32'h0);
    endtask : s_reset

    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        s_edge();
        s_level();
        s_break();
        s_reset();
        end_of_test();
    end
endmodule : keypad_pin_interrupt_tb_top
